// File: inc/decode_pkg.sv
// Shared types and constants for the opcode decoder and bus-cycle sequencer
package decode_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and fixed values
	localparam int           SEQ_MAX      = 12;      // Longest cycle list kept per opcode
	localparam int           CLK_PERIOD_NS = 25;     // Bus clock period, 40 MHz
	localparam int           FREE_NS      = 25;      // A free cycle lasts one bus period
	localparam int           FREE_CYCLES  = (FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]   PREFIX_OPC   = 8'h9e;   // Second-page opcode prefix
	localparam logic [7:0]   VECTOR_PAGE  = 8'hff;   // Vectors live in the top page
	localparam logic [7:0]   DIRECT_PAGE  = 8'h00;   // Direct operands sit in page zero
	localparam logic [3:0]   STORE_COL    = 4'h7;    // Low nibble of store opcodes
	localparam logic [3:0]   JUMP_COL     = 4'hc;    // Low nibble of jump opcodes
	localparam logic [3:0]   CALL_COL     = 4'hd;    // Low nibble of call opcodes
	localparam logic [3:0]   SWI_PUSHES   = 4'd5;    // Bytes stacked on a software trap
	localparam logic [3:0]   SWI_VECTORS  = 4'd2;    // Vector bytes read on a software trap
	localparam logic [15:0]  RESET_WORD   = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Enumerations
	typedef enum logic [3:0] {
		direct_page_mode          = 4'h0,
		full_address_mode         = 4'h1,
		literal_operand_mode      = 4'h2,
		implied_mode              = 4'h3,
		index_plain_mode          = 4'h4,
		index_byte_offset_mode    = 4'h5,
		index_word_offset_mode    = 4'h6,
		index_autoinc_mode        = 4'h7,
		index_offset_autoinc_mode = 4'h8,
		branch_rel_mode           = 4'h9,
		stack_byte_offset_mode    = 4'ha,
		stack_word_offset_mode    = 4'hb
	} mode_e;

	typedef enum logic [2:0] {
		cyc_free   = 3'h0,
		cyc_fetch  = 3'h1,
		cyc_read   = 3'h2,
		cyc_write  = 3'h3,
		cyc_push   = 3'h4,
		cyc_pop    = 3'h5,
		cyc_vector = 3'h6
	} cyc_e;

	typedef enum logic [2:0] {
		acc_none  = 3'h0,
		acc_read  = 3'h1,
		acc_write = 3'h2,
		acc_rmw   = 3'h3,
		acc_push  = 3'h4,
		acc_pop   = 3'h5,
		acc_swi   = 3'h6
	} acc_e;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_run  = 3'b010,
		st_done = 3'b100
	} state_e;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		mode_e                       mode;  // Addressing mode
		logic [2:0]                  len;   // Instruction bytes, prefix included
		logic [3:0]                  ncyc;  // Entries used in seq
		logic [SEQ_MAX-1:0][2:0]     seq;   // Cycle kinds, entry 0 first
	} decode_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} bus_req_s;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [15:0] add_word(input logic [15:0] base, input logic [15:0] off);
		add_word = base + off;
	endfunction

	function automatic acc_e column_access(input logic [7:0] opc);
		if (opc[3:0] == STORE_COL)
			column_access = acc_write;
		else if ((opc[3:0] == JUMP_COL) || (opc[3:0] == CALL_COL))
			column_access = acc_none;
		else
			column_access = acc_read;
	endfunction

endpackage

// File: hdl/opcode_table.sv
// Opcode to addressing mode, byte length and ordered cycle list
`timescale 1ns/1ps
`default_nettype none
module opcode_table
	import decode_pkg::*;
(
	input  wire logic [7:0] opcode_i,   // Opcode byte
	input  wire logic       page2_i,    // Opcode came after the prefix
	output decode_s         dec_o       // Decoded view
);

	mode_e                   mode;
	logic [2:0]              len;
	acc_e                    acc;
	logic [3:0]              k;
	logic [2:0]              nops;
	logic [SEQ_MAX-1:0][2:0] seq;

	// Mode and length per opcode high nibble, with the odd cells patched in
	always_comb begin
		mode = implied_mode;
		len  = 3'd1;
		acc  = acc_none;
		if (page2_i) begin
			len = 3'd2;
			case (opcode_i[7:4])
				4'h6: begin mode = stack_byte_offset_mode; len = 3'd3; acc = acc_rmw; end // see RQ18
				4'hd: begin mode = stack_word_offset_mode; len = 3'd4; acc = column_access(opcode_i); end // see RQ19
				4'he: begin mode = stack_byte_offset_mode; len = 3'd3; acc = column_access(opcode_i); end
				default: ;
			endcase
		end else begin
			case (opcode_i[7:4])
				4'h0: begin mode = direct_page_mode; len = 3'd3; acc = acc_read; end
				4'h1: begin mode = direct_page_mode; len = 3'd2; acc = acc_rmw; end
				4'h2: begin mode = branch_rel_mode; len = 3'd2; end // see RQ17
				4'h3: begin
					mode = direct_page_mode; len = 3'd2; acc = acc_rmw; // see RQ8
					if (opcode_i[3:0] == 4'h1) begin len = 3'd3; acc = acc_read; end
					if (opcode_i[3:0] == 4'h2) begin mode = full_address_mode; len = 3'd3; acc = acc_read; end
					if (opcode_i[3:0] == 4'h5) acc = acc_write;
				end
				4'h4, 4'h5: begin
					if ((opcode_i == 8'h41) || (opcode_i == 8'h51) || (opcode_i == 8'h45)) begin
						mode = literal_operand_mode; len = 3'd3; // see RQ10
					end else if (opcode_i == 8'h55) begin
						mode = direct_page_mode; len = 3'd2; acc = acc_read;
					end
				end
				4'h6: begin
					mode = index_byte_offset_mode; len = 3'd2; acc = acc_rmw; // see RQ13
					if (opcode_i[3:0] == 4'h1) begin mode = index_offset_autoinc_mode; len = 3'd3; acc = acc_read; end
					if (opcode_i[3:0] == 4'h2) begin mode = implied_mode; len = 3'd1; acc = acc_none; end
				end
				4'h7: begin
					mode = index_plain_mode; acc = acc_rmw; // see RQ12
					if (opcode_i[3:0] == 4'h1) begin mode = index_autoinc_mode; len = 3'd2; acc = acc_read; end
					if (opcode_i[3:0] == 4'h2) begin mode = implied_mode; acc = acc_none; end
				end
				4'h8: begin
					if ((opcode_i == 8'h87) || (opcode_i == 8'h89) || (opcode_i == 8'h8b)) acc = acc_push;
					if ((opcode_i == 8'h86) || (opcode_i == 8'h88) || (opcode_i == 8'h8a)) acc = acc_pop;
					if (opcode_i == 8'h83) acc = acc_swi;
				end
				4'h9: begin
					if (opcode_i[3:2] == 2'b00) begin mode = branch_rel_mode; len = 3'd2; end
					if (opcode_i == 8'h96) begin mode = full_address_mode; len = 3'd3; acc = acc_write; end
				end
				4'ha: begin
					mode = literal_operand_mode; len = 3'd2;
					if (opcode_i[3:0] == CALL_COL) mode = branch_rel_mode;
				end
				4'hb: begin mode = direct_page_mode; len = 3'd2; acc = column_access(opcode_i); end
				4'hc: begin mode = full_address_mode; len = 3'd3; acc = column_access(opcode_i); end // see RQ9
				4'hd: begin mode = index_word_offset_mode; len = 3'd3; acc = column_access(opcode_i); end // see RQ14
				4'he: begin mode = index_byte_offset_mode; len = 3'd2; acc = column_access(opcode_i); end
				4'hf: begin mode = index_plain_mode; acc = column_access(opcode_i); end
				default: ;
			endcase
		end
	end

	// Ordered cycle list: operand fetches, data access, then next-opcode fetch
	always_comb begin
		seq  = '0;
		k    = 4'd0;
		nops = len - 3'd1 - {2'b00, page2_i}; // Inherent leaves none, see RQ11
		for (int i = 0; i < 3; i++) begin
			if (i < int'(nops)) begin
				seq[k] = cyc_fetch;
				k      = k + 4'd1;
			end
		end
		case (acc)
			acc_read:  begin seq[k] = cyc_read; k = k + 4'd1; end
			acc_write: begin seq[k] = cyc_write; k = k + 4'd1; end
			acc_rmw: begin
				seq[k]        = cyc_read;
				seq[k + 4'd1] = cyc_free;
				seq[k + 4'd2] = cyc_write;
				k             = k + 4'd3;
			end
			acc_push: begin seq[k] = cyc_push; k = k + 4'd1; end
			acc_pop: begin
				seq[k]        = cyc_free;
				seq[k + 4'd1] = cyc_pop;
				k             = k + 4'd2;
			end
			acc_swi: begin
				for (int i = 0; i < int'(SWI_PUSHES); i++)
					seq[4'(i)] = cyc_push;
				seq[SWI_PUSHES]        = cyc_vector;
				seq[SWI_PUSHES + 4'd1] = cyc_vector;
				seq[SWI_PUSHES + 4'd2] = cyc_free;
				k = SWI_PUSHES + SWI_VECTORS + 4'd1;
			end
			default: ;
		endcase
		seq[k] = cyc_fetch;
		k      = k + 4'd1;
	end

	assign dec_o = '{mode: mode, len: len, ncyc: k, seq: seq}; // see RQ22

endmodule
`default_nettype wire

// File: hdl/ea_calc.sv
// Effective address and branch target arithmetic
`timescale 1ns/1ps
`default_nettype none
module ea_calc
	import decode_pkg::*;
(
	input  wire mode_e       mode_i,     // Addressing mode
	input  wire logic [15:0] hx_i,       // Index pair
	input  wire logic [15:0] sp_i,       // Stack pointer
	input  wire logic [15:0] opnd_i,     // Operand bytes, last byte in low half
	input  wire logic [15:0] pc_next_i,  // Start of the following instruction
	output logic [15:0]      ea_o,       // Effective address
	output logic [15:0]      target_o    // Branch destination
);

	logic [15:0] off8;
	logic [15:0] rel16;

	// Byte offsets are unsigned, the branch byte is signed
	assign off8  = {8'h00, opnd_i[7:0]};
	assign rel16 = {{8{opnd_i[7]}}, opnd_i[7:0]}; // see RQ21

	// Address per mode
	always_comb begin
		case (mode_i)
			direct_page_mode:          ea_o = {DIRECT_PAGE, opnd_i[7:0]}; // see RQ8, see RQ20
			full_address_mode:         ea_o = opnd_i; // see RQ9
			index_plain_mode:          ea_o = hx_i; // see RQ12
			index_autoinc_mode:        ea_o = hx_i; // see RQ15
			index_byte_offset_mode:    ea_o = add_word(hx_i, off8); // see RQ13
			index_offset_autoinc_mode: ea_o = add_word(hx_i, off8); // see RQ16
			index_word_offset_mode:    ea_o = add_word(hx_i, opnd_i); // see RQ14
			stack_byte_offset_mode:    ea_o = add_word(sp_i, off8); // see RQ18
			stack_word_offset_mode:    ea_o = add_word(sp_i, opnd_i); // see RQ19
			default:                   ea_o = RESET_WORD;
		endcase
	end

	assign target_o = add_word(pc_next_i, rel16); // see RQ17, see RQ21

endmodule
`default_nettype wire

// File: hdl/cpu_bus_cycle_and_mode_decode.sv
// Opcode decoder and bus-cycle sequencer of the 8-bit core
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1 - Free cycle: one clock, shown as read
// RQ2 - Program fetch reads next consecutive program byte
// RQ3 - Operand read brings one byte in
// RQ4 - Operand write sends one byte out
// RQ5 - Push writes one byte onto stack
// RQ6 - Pop reads one byte from stack
// RQ7 - Vector read from top page, high first
// RQ8 - Direct mode: operand byte is low address
// RQ9 - Extended mode: two-byte full address
// RQ10 - Immediate mode: value follows the opcode
// RQ11 - Inherent mode: no operand bytes at all
// RQ12 - Plain indexed: index pair is address
// RQ13 - Index plus unsigned byte offset
// RQ14 - Index plus sixteen-bit offset
// RQ15 - Autoincrement: access at index, then increment
// RQ16 - Index plus byte offset, then increment
// RQ17 - Relative: one offset byte is displacement
// RQ18 - Stack pointer plus byte offset
// RQ19 - Stack pointer plus sixteen-bit offset
// RQ20 - Direct address upper byte is zero
// RQ21 - Displacement signed, from next instruction
// RQ22 - Decode gives mode, length, cycle list
module cpu_bus_cycle_and_mode_decode
	import decode_pkg::*;
(
	input  wire logic        mclk_i,        // Bus clock, 40 MHz
	input  wire logic        resetn_i,      // Asynchronous reset, active low
	input  wire logic        start_i,       // Opcode ready, taken when idle
	input  wire logic [7:0]  opcode_i,      // Opcode byte
	input  wire logic        page2_i,       // Opcode followed the prefix
	input  wire logic [15:0] pc_i,          // Address after the opcode byte
	input  wire logic [15:0] hx_i,          // Index pair at start
	input  wire logic [15:0] sp_i,          // Stack pointer at start
	input  wire logic [7:0]  vec_lo_i,      // Low byte of the vector pair
	input  wire logic [7:0]  store_data_i,  // Byte for write and push cycles
	input  wire logic [7:0]  bus_rdata_i,   // Read data of the cycle on the bus
	output bus_req_s         bus_o,         // Bus request of this cycle
	output cyc_e             cyc_kind_o,    // Kind of this bus cycle
	output logic             busy_o,        // Instruction in progress
	output logic             done_o,        // One-cycle pulse, list finished
	output mode_e            mode_o,        // Decoded addressing mode
	output logic [2:0]       len_o,         // Decoded byte length
	output logic [3:0]       ncyc_o,        // Decoded cycle count
	output logic [15:0]      ea_o,          // Effective address in use
	output logic [15:0]      target_o,      // Branch destination
	output logic [15:0]      opnd_o,        // Operand bytes fetched
	output logic [7:0]       rd_data_o,     // Last operand or pop byte read
	output logic [15:0]      hx_o,          // Index pair, after any increment
	output logic             hx_upd_o,      // One-cycle pulse, index pair stepped
	output logic [15:0]      sp_o,          // Stack pointer after push and pop
	output logic [15:0]      pc_o           // Program counter after fetches
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	decode_s     dec_w;
	decode_s     dec_q, dec_d;
	state_e      state_q, state_d;
	logic [3:0]  idx_q, idx_d;
	logic [2:0]  nfetch_q, nfetch_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] sp_q, sp_d;
	logic [15:0] hx_q, hx_d;
	logic [15:0] opnd_q, opnd_d;
	logic [7:0]  vec_lo_q, vec_lo_d;
	logic        vec_hi_done_q, vec_hi_done_d;
	logic [7:0]  rd_data_q, rd_data_d;
	logic        hx_upd_q, hx_upd_d;
	logic        done_q, done_d;
	bus_req_s    bus_q, bus_d;
	cyc_e        kind_q, kind_d;
	logic [15:0] ea_w;
	logic [15:0] target_w;
	logic [15:0] ea_q, ea_d;
	logic [15:0] target_q, target_d;
	logic [2:0]  nopnd;
	logic        autoinc;
	cyc_e        next_kind;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and address arithmetic
	opcode_table u_table (
		.opcode_i (opcode_i),
		.page2_i  (page2_i),
		.dec_o    (dec_w)
	);

	// Fed with the operand bytes as they will stand after this edge, so an access
	// right behind the last operand fetch already sees the full address
	ea_calc u_ea (
		.mode_i    (dec_d.mode),
		.hx_i      (hx_d),
		.sp_i      (sp_d),
		.opnd_i    (opnd_d),
		.pc_next_i (pc_d),
		.ea_o      (ea_w),
		.target_o  (target_w)
	);

	// Operand bytes the instruction takes from the program stream in all
	assign nopnd   = dec_q.len - 3'd1 - {2'b00, (dec_q.ncyc != 4'd0) & page2_prev()};
	assign autoinc = (dec_q.mode == index_autoinc_mode) || (dec_q.mode == index_offset_autoinc_mode);

	// Prefix flag is kept in the length; recover it from the stored mode, set for the two stack-offset modes only
	function automatic logic page2_prev();
		page2_prev = (dec_q.mode == stack_byte_offset_mode) || (dec_q.mode == stack_word_offset_mode);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: retire the cycle on the bus, then line up the next one
	always_comb begin
		state_d       = state_q;
		dec_d         = dec_q;
		idx_d         = idx_q;
		nfetch_d      = nfetch_q;
		pc_d          = pc_q;
		sp_d          = sp_q;
		hx_d          = hx_q;
		opnd_d        = opnd_q;
		vec_lo_d      = vec_lo_q;
		vec_hi_done_d = vec_hi_done_q;
		rd_data_d     = rd_data_q;
		hx_upd_d      = 1'b0;
		done_d        = 1'b0;
		case (state_q)
			st_idle: begin
				if (start_i) begin
					dec_d         = dec_w; // see RQ22
					pc_d          = pc_i;
					sp_d          = sp_i;
					hx_d          = hx_i;
					opnd_d        = RESET_WORD;
					vec_lo_d      = vec_lo_i;
					vec_hi_done_d = 1'b0;
					idx_d         = 4'd0;
					nfetch_d      = 3'd0;
					state_d       = st_run;
				end
			end
			st_run: begin
				case (kind_q)
					cyc_fetch: begin
						pc_d = pc_q + 16'd1; // see RQ2
						if (nfetch_q < nopnd) begin
							// Operand bytes arrive high byte first
							opnd_d   = {opnd_q[7:0], bus_rdata_i}; // see RQ9, see RQ10, see RQ17
							nfetch_d = nfetch_q + 3'd1;
						end
					end
					cyc_read, cyc_pop: rd_data_d = bus_rdata_i; // see RQ3, see RQ6
					cyc_push: sp_d = sp_q - 16'd1; // see RQ5
					cyc_vector: vec_hi_done_d = 1'b1;
					default: ;
				endcase
				if (kind_q == cyc_pop)
					sp_d = sp_q + 16'd1; // see RQ6
				// Step the index pair only after its one data access
				if (autoinc && ((kind_q == cyc_read) || (kind_q == cyc_write))) begin
					hx_d     = hx_q + 16'd1; // see RQ15, see RQ16
					hx_upd_d = 1'b1;
				end
				if (idx_q == dec_q.ncyc - 4'd1) begin
					state_d = st_done;
					done_d  = 1'b1;
				end else begin
					idx_d = idx_q + 4'd1;
				end
			end
			st_done: begin
				state_d = st_idle;
			end
			default: state_d = st_idle;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next bus request from the next cycle kind
	always_comb begin
		bus_d     = '0;
		kind_d    = cyc_free;
		next_kind = cyc_e'(dec_d.seq[idx_d]);
		ea_d      = ea_q;
		target_d  = target_q;
		// Held from when its access is lined up, not moved by index steps
		if ((state_d == st_run) && (next_kind inside {cyc_read, cyc_write}))
			ea_d = ea_w;
		if ((state_q == st_run) && (kind_q == cyc_fetch) && (nfetch_q < nopnd))
			target_d = target_w;
		if (state_d == st_run) begin
			kind_d = next_kind;
			case (next_kind)
				cyc_free: begin
					// No real transfer, but the bus still sees a harmless read
					bus_d.addr = pc_d;
					bus_d.rd   = 1'b1; // see RQ1
				end
				cyc_fetch: begin
					bus_d.addr = pc_d; // see RQ2
					bus_d.rd   = 1'b1;
				end
				cyc_read: begin
					bus_d.addr = ea_w; // see RQ3
					bus_d.rd   = 1'b1;
				end
				cyc_write: begin
					bus_d.addr  = ea_w; // see RQ4
					bus_d.wr    = 1'b1;
					bus_d.wdata = store_data_i; // see RQ4
				end
				cyc_push: begin
					bus_d.addr  = sp_d; // see RQ5
					bus_d.wr    = 1'b1;
					bus_d.wdata = store_data_i;
				end
				cyc_pop: begin
					bus_d.addr = sp_d + 16'd1; // see RQ6
					bus_d.rd   = 1'b1;
				end
				cyc_vector: begin
					// High byte sits at the even address, so it goes first
					bus_d.addr = {VECTOR_PAGE, vec_lo_d[7:1], vec_hi_done_d}; // see RQ7
					bus_d.rd   = 1'b1;
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q       <= st_idle;
			dec_q         <= '0;
			idx_q         <= 4'd0;
			nfetch_q      <= 3'd0;
			pc_q          <= RESET_WORD;
			sp_q          <= RESET_WORD;
			hx_q          <= RESET_WORD;
			opnd_q        <= RESET_WORD;
			vec_lo_q      <= 8'h00;
			vec_hi_done_q <= 1'b0;
			rd_data_q     <= 8'h00;
			hx_upd_q      <= 1'b0;
			done_q        <= 1'b0;
			bus_q         <= '0;
			kind_q        <= cyc_free;
			ea_q          <= RESET_WORD;
			target_q      <= RESET_WORD;
		end else begin
			state_q       <= state_d;
			dec_q         <= dec_d;
			idx_q         <= idx_d;
			nfetch_q      <= nfetch_d;
			pc_q          <= pc_d;
			sp_q          <= sp_d;
			hx_q          <= hx_d;
			opnd_q        <= opnd_d;
			vec_lo_q      <= vec_lo_d;
			vec_hi_done_q <= vec_hi_done_d;
			rd_data_q     <= rd_data_d;
			hx_upd_q      <= hx_upd_d;
			done_q        <= done_d;
			bus_q         <= bus_d; // Every bus cycle lasts one clock, see RQ1
			kind_q        <= kind_d;
			ea_q          <= ea_d;
			target_q      <= target_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign bus_o      = bus_q;
	assign cyc_kind_o = kind_q;
	assign busy_o     = (state_q != st_idle);
	assign done_o     = done_q;
	assign mode_o     = dec_q.mode;
	assign len_o      = dec_q.len;
	assign ncyc_o     = dec_q.ncyc;
	assign ea_o       = ea_q;
	assign target_o   = target_q;
	assign opnd_o     = opnd_q;
	assign rd_data_o  = rd_data_q;
	assign hx_o       = hx_q;
	assign hx_upd_o   = hx_upd_q;
	assign sp_o       = sp_q;
	assign pc_o       = pc_q;

endmodule
`default_nettype wire

// File: dv/cpu_bus_cycle_and_mode_decode_assertions.sv
// Bus-cycle checks on the decoder's top-level ports
`timescale 1ns/1ps
`default_nettype none
module decode_checks
	import decode_pkg::*;
(
	input wire logic     mclk_i,     // Bus clock
	input wire logic     resetn_i,   // Reset, active low
	input wire logic     busy_o,     // Instruction in progress
	input wire logic     done_o,     // List finished
	input wire bus_req_s bus_o,      // Bus request
	input wire cyc_e     cyc_kind_o, // Cycle kind
	input wire mode_e    mode_o      // Addressing mode
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////
	// A list entry is on the bus while busy and before the done pulse
	logic live;
	assign live = busy_o && !done_o;
	sequence s_vec_hi;
		cyc_kind_o == cyc_vector && bus_o.addr[15:8] == VECTOR_PAGE && !bus_o.addr[0];
	endsequence
	sequence s_vec_lo;
		cyc_kind_o == cyc_vector && bus_o.addr[0];
	endsequence
	property p_free_rd;
		live && cyc_kind_o == cyc_free |-> bus_o.rd && !bus_o.wr;
	endproperty
	a_free_rd: assert property (p_free_rd) else $error("free cycle not a read");
	property p_fetch_next;
		(cyc_kind_o == cyc_fetch) ##1 (live && cyc_kind_o == cyc_fetch)
			|-> bus_o.addr == $past(bus_o.addr) + 16'h1;
	endproperty
	a_fetch_next: assert property (p_fetch_next) else $error("fetch skipped");
	property p_read_kinds;
		live && cyc_kind_o inside {cyc_read, cyc_pop, cyc_vector} |-> bus_o.rd && !bus_o.wr;
	endproperty
	a_read_kinds: assert property (p_read_kinds) else $error("read kind bad");
	property p_write_kinds;
		live && cyc_kind_o inside {cyc_write, cyc_push} |-> bus_o.wr && !bus_o.rd;
	endproperty
	a_write_kinds: assert property (p_write_kinds) else $error("write kind bad");
	property p_push_down;
		(cyc_kind_o == cyc_push) ##1 (cyc_kind_o == cyc_push)
			|-> bus_o.addr == $past(bus_o.addr) - 16'h1;
	endproperty
	a_push_down: assert property (p_push_down) else $error("push order bad");
	// Only the first vector cycle of a pair starts the check
	property p_vec_pair;
		cyc_kind_o == cyc_vector && $past(cyc_kind_o) != cyc_vector |-> s_vec_hi ##1 s_vec_lo;
	endproperty
	a_vec_pair: assert property (p_vec_pair) else $error("vector pair bad");
	property p_direct_page;
		live && mode_o == direct_page_mode && cyc_kind_o inside {cyc_read, cyc_write}
			|-> bus_o.addr[15:8] == DIRECT_PAGE;
	endproperty
	a_direct_page: assert property (p_direct_page) else $error("direct page bad");
	property p_done_idle;
		done_o |=> !busy_o && !done_o;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("busy after done");
endmodule
`default_nettype wire

// File: dv/decode_mem_model.sv
// Behavioural memory standing on the far side of the system bus
`timescale 1ns/1ps
`default_nettype none
module decode_mem_model
	import decode_pkg::*;
(
	input  wire bus_req_s bus_i,   // Request from the decoder
	output logic [7:0]    rdata_o  // Byte for this cycle
);
	// Bytes follow the address; outside reads the bus shows the inverse,
	// so sampling at the wrong moment cannot pass by luck
	always_comb begin
		rdata_o = bus_i.addr[7:0] ^ 8'h3c;
		if (!bus_i.rd) begin
			rdata_o = ~rdata_o;
		end
	end
endmodule
`default_nettype wire

// File: dv/cpu_bus_cycle_and_mode_decode_tb.sv
// Self-checking bench for the decoder and bus-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cycle_and_mode_decode_tb;
	import decode_pkg::*;
	logic        mclk_i = 1'b0, resetn_i = 1'b0, start_i = 1'b0, page2_i = 1'b0;
	logic [7:0]  opcode_i = 8'h0, vec_lo_i = 8'h0, store_data_i = 8'h0;
	logic [15:0] pc_i = 16'h0, hx_i = 16'h0, sp_i = 16'h0;
	logic        busy_o, done_o, hx_upd_o;
	logic [7:0]  bus_rdata_i, rd_data_o;
	logic [15:0] ea_o, target_o, opnd_o, hx_o, sp_o, pc_o;
	logic [2:0]  len_o;
	logic [3:0]  ncyc_o;
	bus_req_s    bus_o;
	cyc_e        cyc_kind_o;
	mode_e       mode_o;
	int          failures = 0, checks_done = 0;
	cyc_e        kq[$];
	logic [15:0] aq[$];
	logic [7:0]  dq[$];
	cpu_bus_cycle_and_mode_decode u_cpu_bus_cycle_and_mode_decode (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(start_i), .opcode_i(opcode_i),
		.page2_i(page2_i), .pc_i(pc_i), .hx_i(hx_i), .sp_i(sp_i), .vec_lo_i(vec_lo_i),
		.store_data_i(store_data_i), .bus_rdata_i(bus_rdata_i), .bus_o(bus_o),
		.cyc_kind_o(cyc_kind_o), .busy_o(busy_o), .done_o(done_o), .mode_o(mode_o),
		.len_o(len_o), .ncyc_o(ncyc_o), .ea_o(ea_o), .target_o(target_o), .opnd_o(opnd_o),
		.rd_data_o(rd_data_o), .hx_o(hx_o), .hx_upd_o(hx_upd_o), .sp_o(sp_o), .pc_o(pc_o));
	decode_mem_model u_decode_mem_model (.bus_i(bus_o), .rdata_o(bus_rdata_i));
	always #12.5 mclk_i = ~mclk_i;
	////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Start one opcode and log every bus cycle until done; bounded wait
	task automatic run(input logic [7:0] op, input logic p2);
		int n;
		kq.delete();
		aq.delete();
		dq.delete();
		opcode_i = op;
		page2_i = p2;
		start_i = 1'b1;
		@(negedge mclk_i);
		start_i = 1'b0;
		for (n = 0; n < 40 && done_o !== 1'b1; n++) begin
			kq.push_back(cyc_kind_o);
			aq.push_back(bus_o.addr);
			dq.push_back(bus_o.wdata);
			@(negedge mclk_i);
		end
		chk("done", 16'h1, {15'h0, done_o});
		@(negedge mclk_i);
	endtask
	////////////////////////////////////////
	// Opcode order matches the mode encoding, so index i is the expected mode
	task automatic t_modes();
		logic [7:0]  ops[12] = '{8'hb6, 8'hc6, 8'ha6, 8'h9d, 8'hf6, 8'he6, 8'hd6, 8'h71,
			8'h61, 8'h20, 8'he6, 8'hd6};
		logic [2:0]  ln[12] = '{3'h2, 3'h3, 3'h2, 3'h1, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h2,
			3'h3, 3'h4};
		logic [15:0] ea[12] = '{16'h007c, 16'h7c7d, 16'h0, 16'h0, 16'h0300, 16'h037c,
			16'h7f7d, 16'h0300, 16'h037d, 16'h0, 16'h016c, 16'h7d6d};
		pc_i = 16'h1240;
		hx_i = 16'h0300;
		sp_i = 16'h00f0;
		for (int i = 0; i < 12; i++) begin
			run(ops[i], i > 9);
			chk("mode", 16'(i), {12'h0, mode_o});
			chk("len", {13'h0, ln[i]}, {13'h0, len_o});
			chk("ncyc", 16'(kq.size()), {12'h0, ncyc_o});
			if (!(i inside {2, 3, 9})) begin
				chk("ea", ea[i], ea_o);
			end
			chk("hx", 16'h0300 + 16'(i == 7 || i == 8), hx_o);
		end
	endtask
	task automatic t_operands();
		pc_i = 16'h1240;
		run(8'ha6, 1'b0);
		chk("opnd", 16'h007c, opnd_o);
		run(8'h20, 1'b0);
		chk("target", 16'h12bd, target_o);
	endtask
	// Both ends of the displacement range
	task automatic t_branch_edges();
		pc_i = 16'h12bc;
		run(8'h20, 1'b0);
		chk("target", 16'h123d, target_o);
		pc_i = 16'h1243;
		run(8'h20, 1'b0);
		chk("target", 16'h12c3, target_o);
	endtask
	task automatic t_ext_load();
		cyc_e        k[4] = '{cyc_fetch, cyc_fetch, cyc_read, cyc_fetch};
		logic [15:0] a[4] = '{16'h1240, 16'h1241, 16'h7c7d, 16'h1242};
		pc_i = 16'h1240;
		run(8'hc6, 1'b0);
		for (int i = 0; i < 4; i++) begin
			chk("kind", {13'h0, k[i]}, {13'h0, kq[i]});
			chk("addr", a[i], aq[i]);
		end
		chk("rdata", 16'h0041, {8'h0, rd_data_o});
		chk("pc", 16'h1243, pc_o);
	endtask
	task automatic t_store();
		store_data_i = 8'ha5;
		run(8'hc7, 1'b0);
		chk("kind", {13'h0, cyc_write}, {13'h0, kq[2]});
		chk("addr", 16'h7c7d, aq[2]);
		chk("wdata", 16'h00a5, {8'h0, dq[2]});
	endtask
	task automatic t_swi();
		sp_i = 16'h00f0;
		vec_lo_i = 8'hfb;
		run(8'h83, 1'b0);
		for (int i = 0; i < 5; i++) begin
			chk("kind", {13'h0, cyc_push}, {13'h0, kq[i]});
			chk("addr", 16'h00f0 - 16'(i), aq[i]);
		end
		chk("kind", {13'h0, cyc_vector}, {13'h0, kq[5]});
		chk("addr", 16'hfffa, aq[5]);
		chk("addr", 16'hfffb, aq[6]);
	endtask
	task automatic t_pop();
		sp_i = 16'h00f0;
		run(8'h86, 1'b0);
		chk("kind", {13'h0, cyc_free}, {13'h0, kq[0]});
		chk("kind", {13'h0, cyc_pop}, {13'h0, kq[1]});
		chk("addr", 16'h00f1, aq[1]);
		chk("sp", 16'h00f1, sp_o);
		chk("rdata", 16'h00cd, {8'h0, rd_data_o});
	endtask
	////////////////////////////////////////
	// Main sequence after two reset cycles
	initial begin
		repeat (2) @(negedge mclk_i);
		resetn_i = 1'b1;
		@(negedge mclk_i);
		t_modes();
		t_operands();
		t_branch_edges();
		t_ext_load();
		t_store();
		t_swi();
		t_pop();
		test_done();
	end
	// Watchdog, well beyond the hundred or so cycles the run needs
	initial begin
		#(2000 * 25);
		failures++;
		test_done();
	end
endmodule
bind cpu_bus_cycle_and_mode_decode decode_checks u_decode_checks (.mclk_i(mclk_i),
	.resetn_i(resetn_i), .busy_o(busy_o), .done_o(done_o), .bus_o(bus_o),
	.cyc_kind_o(cyc_kind_o), .mode_o(mode_o));
`default_nettype wire
